// file: include/qec_pkg.sv
package qec_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_IDX_HIGH  = 8'h04;
    localparam logic [7:0] OFF_IDX_LOW   = 8'h08;
    localparam logic [7:0] OFF_TMR_HIGH  = 8'h0c;
    localparam logic [7:0] OFF_TMR_LOW   = 8'h10;
    localparam logic [7:0] OFF_POS_HIGH  = 8'h14;
    localparam logic [7:0] OFF_POS_LOW   = 8'h18;
    localparam logic [7:0] OFF_INPUTS    = 8'h1c;
    // control field positions
    localparam int CTL_MODE_LSB  = 0;
    localparam int CTL_GATE_BIT  = 2;
    localparam int CTL_POL_BIT   = 3;
    localparam int CTL_DIV_LSB   = 4;
    localparam int CTL_PIMOD_LSB = 7;
    localparam int CTL_IMV_LSB   = 10;
    localparam int CTL_SWAP_BIT  = 12;
    localparam int CTL_INVA_BIT  = 13;
    localparam int CTL_INVB_BIT  = 14;
    localparam logic [15:0] CTL_RESET    = 16'h0000;
    localparam logic [15:0] CTL_WMASK    = 16'h7fff;
    localparam logic [1:0]  AXI_OKAY     = 2'h0;
    localparam logic [1:0]  AXI_SLVERR   = 2'h2;
    typedef enum logic [1:0] {
        QEC_MODE_QUAD  = 2'h0,
        QEC_MODE_EXTUD = 2'h1,
        QEC_MODE_EXTCK = 2'h2,
        QEC_MODE_TIMER = 2'h3
    } qec_mode_t;
endpackage

// file: core/qec_prescaler.sv
`timescale 1ns/1ns
module qec_prescaler #(
    parameter int SEL_W = 3
) (
    input  wire logic             clk_sys,  // system clock
    input  wire logic             arst_n,   // async reset
    input  wire logic [SEL_W-1:0] sel,      // divide by 2**sel
    output logic                  tick      // one-cycle enable
);
    localparam int CNT_W = (1 << SEL_W) - 1;
    logic [(1<<SEL_W)-2:0] cnt;
    wire  [(1<<SEL_W)-2:0] limit = CNT_W'((1 << sel) - 1);
    wire                   wrap  = (cnt >= limit);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= wrap ? '0 : cnt + 1'b1;
            tick <= wrap;
        end
    end

    a_tick_period: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(arst_n) && sel == 3'h0 && $past(sel) == 3'h0 && $past(sel, 2) == 3'h0) |-> tick)
        else $error("prescaler 1:1 did not tick every cycle");
endmodule

// file: core/qec_quad_decoder.sv
`timescale 1ns/1ns
module qec_quad_decoder (
    input  wire logic clk_sys,  // system clock
    input  wire logic arst_n,   // async reset
    input  wire logic phase_a,  // conditioned phase a
    input  wire logic phase_b,  // conditioned phase b
    output logic      step,     // one-cycle count pulse
    output logic      dir_dn    // direction of the step
);
    logic a_q;
    logic b_q;
    wire  moved = (phase_a ^ a_q) ^ (phase_b ^ b_q);
    // a leads b counts up: a new ^ b old
    wire  dn    = ~(phase_a ^ b_q);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            a_q    <= 1'b0;
            b_q    <= 1'b0;
            step   <= 1'b0;
            dir_dn <= 1'b0;
        end else begin
            a_q    <= phase_a;
            b_q    <= phase_b;
            step   <= moved;
            dir_dn <= dn;
        end
    end

    a_single_edge: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($changed(phase_a) && $stable(phase_b)) |=> step)
        else $error("a edge produced no step");
endmodule

// file: core/qec_core.sv
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - three-bit prescale selects counter clock divide 1 to 128 in powers of two.
// - polarity bit set counts down by default; external up/down may override.
// - gate enable set lets gate input stop the position counter.
// - mode 00 counts quadrature x4; mode 01 counts clock pulses with up/down input.
// - mode 10 counts external clock; mode 11 is internal timer mode.
// - modes 10 and 11 make the index counter a timer, and mode 11 the position counter too; init mode ignored.
// - in mode 00, position count clears when a and b equal match value.
// - match compares a and b after swap and inversion are applied.
// - index counter is two readable writable 16-bit words, zero at reset.
// - interval timer is two readable writable 16-bit words, zero at reset.
module qec_core (
    input  wire logic        clk_sys,        // 20 MHz clock
    input  wire logic        arst_n,         // async reset, low
    input  wire logic        encoder_phase_a,// encoder a / ext clock
    input  wire logic        encoder_phase_b,// encoder b / up-down
    input  wire logic        index_in,       // index pulse
    input  wire logic        gate_in,        // count gate
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // byte enables
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready,   // read data ready
    output logic             counter_dir_dn  // registered count direction
);
    logic [15:0] encoder_control;
    logic [31:0] index_counter_32;
    logic [31:0] interval_timer_32;
    logic [31:0] position_count;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        idx_q;
    logic        gate_q;
    logic        bclk_q;

    // control fields
    wire [1:0] counter_mode_sel         = encoder_control[qec_pkg::CTL_MODE_LSB +: 2];
    wire       gate_input_enable        = encoder_control[qec_pkg::CTL_GATE_BIT];
    wire       count_direction_polarity = encoder_control[qec_pkg::CTL_POL_BIT];
    wire [2:0] clock_prescale_sel       = encoder_control[qec_pkg::CTL_DIV_LSB +: 3];
    wire [2:0] position_init_mode       = encoder_control[qec_pkg::CTL_PIMOD_LSB +: 3];
    wire [1:0] index_match_value        = encoder_control[qec_pkg::CTL_IMV_LSB +: 2];
    wire       swap_ab                  = encoder_control[qec_pkg::CTL_SWAP_BIT];
    wire       inv_a                    = encoder_control[qec_pkg::CTL_INVA_BIT];
    wire       inv_b                    = encoder_control[qec_pkg::CTL_INVB_BIT];

    // conditioned inputs
    wire cond_a = (swap_ab ? encoder_phase_b : encoder_phase_a) ^ inv_a;
    wire cond_b = (swap_ab ? encoder_phase_a : encoder_phase_b) ^ inv_b;

    wire tick;
    wire q_step;
    wire q_dn;

    qec_prescaler #(.SEL_W(3)) u_div (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sel     (clock_prescale_sel),
        .tick    (tick)
    );

    qec_quad_decoder u_quad (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .phase_a (cond_a),
        .phase_b (cond_b),
        .step    (q_step),
        .dir_dn  (q_dn)
    );

    wire is_quad   = (counter_mode_sel == qec_pkg::QEC_MODE_QUAD);
    wire is_extud  = (counter_mode_sel == qec_pkg::QEC_MODE_EXTUD);
    wire is_timer  = counter_mode_sel[1];
    wire gate_ok   = !gate_input_enable || gate_q;
    wire ext_edge  = cond_a && !bclk_q;
    wire ext_ud_dn = count_direction_polarity ^ cond_b;
    wire dir_dn    = is_quad ? (q_dn ^ count_direction_polarity)
                             : (is_extud ? ext_ud_dn : count_direction_polarity);
    // ext clock edge in 01/10, prescaled clock in 11
    wire step_ext  = (counter_mode_sel == qec_pkg::QEC_MODE_TIMER) ? tick : (ext_edge && tick);
    wire pos_step  = (is_quad ? (q_step && tick) : step_ext) && gate_ok;
    wire idx_edge  = is_timer ? tick : (index_in && !idx_q && tick);
    wire ab_match  = is_quad && ({cond_a, cond_b} == index_match_value);
    wire pimod_en  = !is_timer && (position_init_mode != 3'h0);

    // bus handshake
    wire aw_ok   = aw_held && w_held && !s_axi_bvalid;
    wire [7:0] wa = aw_addr;
    wire [7:0] ra = s_axi_araddr;
    wire wr_ctl  = aw_ok && (wa == qec_pkg::OFF_CONTROL);
    wire wr_ih   = aw_ok && (wa == qec_pkg::OFF_IDX_HIGH);
    wire wr_il   = aw_ok && (wa == qec_pkg::OFF_IDX_LOW);
    wire wr_th   = aw_ok && (wa == qec_pkg::OFF_TMR_HIGH);
    wire wr_tl   = aw_ok && (wa == qec_pkg::OFF_TMR_LOW);
    wire wr_ph   = aw_ok && (wa == qec_pkg::OFF_POS_HIGH);
    wire wr_pl   = aw_ok && (wa == qec_pkg::OFF_POS_LOW);
    wire wr_hit  = wr_ctl || wr_ih || wr_il || wr_th || wr_tl || wr_ph || wr_pl;
    wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [15:0] wlo   = w_data[15:0];

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // read decode
    logic [15:0] rd_word;
    logic        rd_hit;
    assign rd_hit = (ra == qec_pkg::OFF_CONTROL) || (ra == qec_pkg::OFF_IDX_HIGH) ||
                    (ra == qec_pkg::OFF_IDX_LOW) || (ra == qec_pkg::OFF_TMR_HIGH) ||
                    (ra == qec_pkg::OFF_TMR_LOW) || (ra == qec_pkg::OFF_POS_HIGH) ||
                    (ra == qec_pkg::OFF_POS_LOW) || (ra == qec_pkg::OFF_INPUTS);
    always_comb begin
        if (ra == qec_pkg::OFF_CONTROL)       rd_word = encoder_control;
        else if (ra == qec_pkg::OFF_IDX_HIGH) rd_word = index_counter_32[31:16];
        else if (ra == qec_pkg::OFF_IDX_LOW)  rd_word = index_counter_32[15:0];
        else if (ra == qec_pkg::OFF_TMR_HIGH) rd_word = interval_timer_32[31:16];
        else if (ra == qec_pkg::OFF_TMR_LOW)  rd_word = interval_timer_32[15:0];
        else if (ra == qec_pkg::OFF_POS_HIGH) rd_word = position_count[31:16];
        else if (ra == qec_pkg::OFF_POS_LOW)  rd_word = position_count[15:0];
        else if (ra == qec_pkg::OFF_INPUTS)   rd_word = {12'h000, gate_q, idx_q, cond_b, cond_a};
        else                                  rd_word = 16'h0000;
    end

    // next values of counters
    wire [31:0] pos_inc  = dir_dn ? position_count - 32'h1 : position_count + 32'h1;
    wire [31:0] idx_inc  = (count_direction_polarity && !is_timer) ? index_counter_32 - 32'h1
                                                                   : index_counter_32 + 32'h1;
    logic [31:0] next_pos;
    logic [31:0] next_idx;
    logic [31:0] next_tmr;
    always_comb begin
        next_pos = position_count;
        if (ab_match)       next_pos = 32'h0;
        else if (pos_step)  next_pos = pos_inc;
        else if (pimod_en && index_in && !idx_q && tick) next_pos = 32'h0;
        if (wr_ph) next_pos[31:16] = merge(position_count[31:16], wlo, wmask);
        if (wr_pl) next_pos[15:0]  = merge(position_count[15:0], wlo, wmask);
        next_idx = idx_edge ? idx_inc : index_counter_32;
        if (wr_ih) next_idx[31:16] = merge(index_counter_32[31:16], wlo, wmask);
        if (wr_il) next_idx[15:0]  = merge(index_counter_32[15:0], wlo, wmask);
        next_tmr = (tick && gate_ok) ? interval_timer_32 + 32'h1 : interval_timer_32;
        if (wr_th) next_tmr[31:16] = merge(interval_timer_32[31:16], wlo, wmask);
        if (wr_tl) next_tmr[15:0]  = merge(interval_timer_32[15:0], wlo, wmask);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            position_count    <= 32'h0;
            index_counter_32  <= 32'h0;
            interval_timer_32 <= 32'h0;
            encoder_control   <= qec_pkg::CTL_RESET;
            idx_q             <= 1'b0;
            gate_q            <= 1'b0;
            bclk_q            <= 1'b0;
            counter_dir_dn    <= 1'b0;
        end else begin
            position_count    <= next_pos;
            index_counter_32  <= next_idx;
            interval_timer_32 <= next_tmr;
            if (wr_ctl)
                encoder_control <= merge(encoder_control, wlo, wmask) & qec_pkg::CTL_WMASK;
            idx_q             <= index_in;
            gate_q            <= gate_in;
            if (tick)
                bclk_q <= cond_a;
            counter_dir_dn    <= dir_dn;
        end
    end

    // axi-lite write channel
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= qec_pkg::AXI_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_ok) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? qec_pkg::AXI_OKAY : qec_pkg::AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi-lite read channel
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= qec_pkg::AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {16'h0000, rd_word};
                s_axi_rresp  <= rd_hit ? qec_pkg::AXI_OKAY : qec_pkg::AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_match_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ab_match && !wr_ph && !wr_pl) |=> (position_count == 32'h0))
        else $error("index match did not clear position");
    a_gate_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (gate_input_enable && !gate_q && !ab_match && !wr_ph && !wr_pl && !pimod_en)
        |=> $stable(position_count))
        else $error("gated position counter moved");
    a_quad_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (is_quad && pos_step && !dir_dn && !ab_match && !wr_ph && !wr_pl)
        |=> (position_count == $past(position_count) + 32'h1))
        else $error("quadrature step did not count up by one");
    a_timer_mode: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (is_timer && tick && !wr_il && !wr_ih)
        |=> (index_counter_32 == $past(index_counter_32) + 32'h1))
        else $error("timer mode index counter did not advance");
    a_polarity_down: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (counter_mode_sel == qec_pkg::QEC_MODE_TIMER && count_direction_polarity) |=> counter_dir_dn)
        else $error("polarity did not set down direction");
    a_idx_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (wr_il && w_strb[1:0] == 2'h3) |=> (index_counter_32[15:0] == $past(w_data[15:0])))
        else $error("index low write lost");
    a_tmr_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (wr_th && w_strb[1:0] == 2'h3) |=> (interval_timer_32[31:16] == $past(w_data[15:0])))
        else $error("timer high write lost");
    a_mode_extud: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (is_extud && !ext_edge) |-> !pos_step)
        else $error("ext count stepped without clock edge");
    a_timer_tick: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (counter_mode_sel == qec_pkg::QEC_MODE_TIMER && tick && gate_ok) |-> pos_step)
        else $error("timer mode missed a tick");
    // direction, timer, gating, refusal, control mask and write response hold checks
    a_index_down: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (idx_edge && !is_timer && count_direction_polarity && !wr_il && !wr_ih)
        |=> (index_counter_32 == $past(index_counter_32) - 32'h1))
        else $error("index counter did not count down");
    a_timer_pos: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (is_timer && pos_step && !dir_dn && !wr_ph && !wr_pl)
        |=> (position_count == $past(position_count) + 32'h1))
        else $error("timer mode position did not advance");
    a_gate_timer: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (gate_input_enable && !gate_q && !wr_th && !wr_tl) |=> $stable(interval_timer_32))
        else $error("gated interval timer moved");
    a_quad_tick: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (is_quad && !tick) |-> !pos_step)
        else $error("quadrature step without prescale tick");
    a_write_slverr: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (aw_ok && !wr_hit) |=> (s_axi_bvalid && s_axi_bresp == qec_pkg::AXI_SLVERR))
        else $error("unmapped write not refused");
    a_read_slverr: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_axi_arvalid && s_axi_arready && !rd_hit)
        |=> (s_axi_rvalid && s_axi_rresp == qec_pkg::AXI_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    a_ctl_mask: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_ctl |=> (encoder_control[15] == 1'b0))
        else $error("control top bit became set");
    a_bvalid_stands: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before ready");
    c_quad_count: cover property (@(posedge clk_sys) disable iff (!arst_n) is_quad && pos_step);
    c_match: cover property (@(posedge clk_sys) disable iff (!arst_n) ab_match && position_count != 32'h0);
    c_write: cover property (@(posedge clk_sys) disable iff (!arst_n) s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge clk_sys) disable iff (!arst_n) s_axi_rvalid && s_axi_rready);
    c_timer_mode: cover property (@(posedge clk_sys) disable iff (!arst_n) is_timer && pos_step);
endmodule

// file: dv/qec_encoder_model.sv
`timescale 1ns/1ns
module qec_encoder_model #(
    parameter int HOLD = 4
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic step_req, // request one step
    input  wire logic step_dn,  // step backwards
    output logic      phase_a,  // encoder a
    output logic      phase_b,  // encoder b
    output logic      busy      // holding last step
);
    logic [1:0] pos = 2'h0;
    int         hold_cnt = 0;
    // gray order 00 01 11 10, each state held at least HOLD+1 cycles
    always @(posedge clk_sys) begin
        if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end else if (step_req) begin
            pos      <= step_dn ? pos - 2'h1 : pos + 2'h1;
            hold_cnt <= HOLD;
        end
    end
    assign phase_a = pos[1];
    assign phase_b = pos[1] ^ pos[0];
    assign busy    = hold_cnt != 0;
endmodule

// file: dv/test_quadrature_encoder_counters.sv
`timescale 1ns/1ns
module test_quadrature_encoder_counters;
    logic        clk_sys = 1'h0, arst_n = 1'h0, index_in = 1'h0, gate_in = 1'h1;
    logic        raw_en = 1'h0, raw_a = 1'h0, raw_b = 1'h0, step_req = 1'h0, step_dn = 1'h0;
    logic        mdl_a, mdl_b, dir_dn, awready, wready, bvalid, arready, rvalid;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v, p0, p1, p2;
    logic [1:0]  bresp, rresp, resp;
    int          err_total = 0, n_compared = 0, n;
    wire logic   ph_a = raw_en ? raw_a : mdl_a;
    wire logic   ph_b = raw_en ? raw_b : mdl_b;
    always #25 clk_sys = ~clk_sys;
    qec_core u_qec_core (.clk_sys(clk_sys), .arst_n(arst_n), .encoder_phase_a(ph_a), .encoder_phase_b(ph_b),
        .index_in(index_in), .gate_in(gate_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .counter_dir_dn(dir_dn));
    qec_encoder_model u_qec_encoder_model (.clk_sys(clk_sys), .step_req(step_req), .step_dn(step_dn),
        .phase_a(mdl_a), .phase_b(mdl_b), .busy());
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'h1) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task timeout_hit;
        err_total++;
        $display("mismatch t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        give_verdict;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        resp = bresp;
        bready <= 1'h0;
        if (n == 100) timeout_hit;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        d = rdata; resp = rresp;
        rready <= 1'h0;
        if (n == 100) timeout_hit;
    endtask
    task rd_pos(output logic [31:0] p);
        logic [31:0] h;
        rd(qec_pkg::OFF_POS_HIGH, h);
        rd(qec_pkg::OFF_POS_LOW, p);
        p = {h[15:0], p[15:0]};
    endtask
    task steps(input logic dn, input int k);
        repeat (k) begin
            @(posedge clk_sys); step_req <= 1'h1; step_dn <= dn;
            @(posedge clk_sys); step_req <= 1'h0;
            repeat (6) @(posedge clk_sys);
        end
    endtask
    task pulses(input int k);
        repeat (k) begin
            @(posedge clk_sys); raw_a <= 1'h1;
            repeat (2) @(posedge clk_sys); raw_a <= 1'h0;
            repeat (2) @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
    endtask
    task idx_pulse;
        @(posedge clk_sys); index_in <= 1'h1;
        repeat (2) @(posedge clk_sys); index_in <= 1'h0;
    endtask
    function automatic logic [31:0] mag(input logic [31:0] d, input logic [31:0] m);
        return {31'h0, (d === m) || (d === -m)};
    endfunction
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'h1;
        // timer runs at 1:1 from release: one tick lands before the first read is taken
        rd(qec_pkg::OFF_TMR_LOW, v); chk(v, 32'h1);
        for (int i = 1; i < 4; i++) begin
            rd(8'(i) * 8'h04, v); chk(v, 32'h0);
        end
        $display("test reset values done");
        wr(qec_pkg::OFF_CONTROL, 32'hffff); rd(qec_pkg::OFF_CONTROL, v); chk(v, 32'h7fff);
        wr(qec_pkg::OFF_CONTROL, 32'h0004); gate_in <= 1'h0;
        wr(qec_pkg::OFF_TMR_HIGH, 32'hffff1234); wr(qec_pkg::OFF_TMR_LOW, 32'h0000abcd);
        rd(qec_pkg::OFF_TMR_HIGH, v); chk(v, 32'h1234);
        rd(qec_pkg::OFF_TMR_LOW, v); chk(v, 32'habcd);
        wr(qec_pkg::OFF_IDX_HIGH, 32'h00005a5a); wr(qec_pkg::OFF_IDX_LOW, 32'h0000a5a5);
        rd(qec_pkg::OFF_IDX_HIGH, v); chk(v, 32'h5a5a);
        rd(qec_pkg::OFF_IDX_LOW, v); chk(v, 32'ha5a5);
        rd(8'h20, v); chk(v, 32'h0); chk({30'h0, resp}, {30'h0, qec_pkg::AXI_SLVERR});
        wr(8'h24, 32'h1); chk({30'h0, resp}, {30'h0, qec_pkg::AXI_SLVERR});
        $display("test register access done");
        gate_in <= 1'h1;
        wr(qec_pkg::OFF_CONTROL, 32'h0000); steps(1'h0, 3); rd_pos(p1);
        chk(mag(p1, 32'h3), 32'h1);
        steps(1'h1, 3); rd_pos(v); chk(v, 32'h0);
        wr(qec_pkg::OFF_CONTROL, 32'h0008); steps(1'h0, 3); rd_pos(p2);
        chk(p2, -p1);
        steps(1'h1, 3);
        wr(qec_pkg::OFF_CONTROL, 32'h2800); rd_pos(v); chk(v, 32'h0);
        steps(1'h0, 3); rd_pos(v); chk(mag(v, 32'h3), 32'h1);
        steps(1'h1, 3);
        $display("test quadrature done");
        raw_en <= 1'h1;
        wr(qec_pkg::OFF_CONTROL, 32'h0001); rd_pos(p0); pulses(5); rd_pos(p1);
        chk(mag(p1 - p0, 32'h5), 32'h1); chk({31'h0, dir_dn}, 32'h0);
        raw_b <= 1'h1; pulses(5); rd_pos(p2);
        chk(p2, p0); chk({31'h0, dir_dn}, 32'h1);
        wr(qec_pkg::OFF_CONTROL, 32'h0005); gate_in <= 1'h0; pulses(5); rd_pos(v);
        chk(v, p2);
        gate_in <= 1'h1; pulses(5); rd_pos(v); chk(mag(v - p2, 32'h5), 32'h1);
        $display("test external count done");
        wr(qec_pkg::OFF_CONTROL, 32'h0088); rd(qec_pkg::OFF_IDX_LOW, p0); idx_pulse;
        rd(qec_pkg::OFF_IDX_LOW, p1); chk(p1, p0 - 32'h1);
        rd_pos(v); chk(v, 32'h0);
        $display("test index done");
        for (int s = 0; s < 8; s++) begin
            wr(qec_pkg::OFF_CONTROL, 32'(s) << 4); rd(qec_pkg::OFF_TMR_LOW, p0);
            repeat (256) @(posedge clk_sys);
            rd(qec_pkg::OFF_TMR_LOW, p1);
            chk_rng((p1 - p0) & 32'hffff, 32'd256 >> s, (32'd264 >> s) + 32'h1);
        end
        $display("test prescale done");
        for (int m = 2; m < 4; m++) begin
            wr(qec_pkg::OFF_CONTROL, 32'(m) | 32'h0080); rd(qec_pkg::OFF_IDX_LOW, p0);
            repeat (64) @(posedge clk_sys);
            rd(qec_pkg::OFF_IDX_LOW, p1); chk_rng((p1 - p0) & 32'hffff, 32'd64, 32'd73);
            if (m == 3) begin
                rd_pos(p1); idx_pulse;
                rd_pos(p2); chk_rng(p2 - p1, 32'h1, 32'h28);
            end
        end
        $display("test timer modes done");
        give_verdict;
    end
endmodule
